// file: plvc_ctrl.sv
// Bleed offset, lock detect and oscillator calibration control with Avalon-MM registers
//
// What this block does
// - Bleed current drives the charge pump only while bleed enable is set.
// - Direction bit 1 sources constant current, 0 sinks it.
// - Each magnitude step adds 536 nA; delay step follows current over ICP times fPFD.
// - Ten-bit unsigned magnitude; direction 0 lengthens delay, 1 shortens it.
// - Lock detector runs only with both enables set; drives pin and status bit.
// - Lock result also goes to the test pin when its select code is chosen.
// - Lock shown only after enough consecutive PFD cycles inside the window.
// - Five-bit count select picks cycles from fixed table, 23 up to 1112181.
// - Lock low while counting, high at count, drops at once on window exit.
// - Window width bit: 0 allows 150 ps offset, 1 allows 250 ps.
// - Four cores of 256 bands; calibration picks core, band and bias.
// - Any write to the main divider register starts calibration.
// - Both busy flags high while calibrating; converter busy falls before sequencer busy.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module plvc_ctrl (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [plvc_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [plvc_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [plvc_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          pfd_tick,
  input  wire logic                          phase_in_window,
  input  wire logic                          cal_tick,
  input  wire logic                          osc_freq_low,
  input  wire logic [plvc_pkg::BIAS_W-1:0]   amp_level,
  output logic                               bleed_source_on,
  output logic                               bleed_sink_on,
  output logic      [plvc_pkg::BLEED_W-1:0]  bleed_magnitude,
  output logic                               lock_window_width,
  output logic                               lock_indicate_pin,
  output logic                               test_output_pin,
  output logic                               output_logic_level_select,
  output logic      [11:0]                   feedback_divide,
  output logic      [1:0]                    output_divide_select,
  output logic      [5:0]                    reference_divide,
  output logic                               reference_doubler_enable,
  output logic      [1:0]                    cal_clock_first_divider,
  output logic      [1:0]                    cal_clock_second_divider,
  output logic                               cal_clock_mode,
  output logic                               cal_count_select,
  output logic                               cal_ref_clock_enable,
  output logic                               cal_feedback_clock_enable,
  output logic                               cal_adc_clock_enable,
  output logic      [plvc_pkg::ADIV_W-1:0]   adc_clock_divide,
  output logic      [plvc_pkg::CORE_W-1:0]   oscillator_core_result,
  output logic      [plvc_pkg::BAND_W-1:0]   oscillator_band_result,
  output logic      [plvc_pkg::BIAS_W-1:0]   oscillator_bias_result
);
  import plvc_pkg::*;

  typedef struct packed {
    logic                  ack;
    logic [DATA_W-1:0]     rdata;
    logic [DATA_W-1:0]     main_div;
    logic [DATA_W-1:0]     bleed;
    logic [DATA_W-1:0]     lock_cfg;
    logic [DATA_W-1:0]     cal_clk;
    logic [DATA_W-1:0]     cal_tmo;
    logic [DATA_W-1:0]     band_div;
    logic [DATA_W-1:0]     manual;
    plvc_cal_state_t       st;
    logic [TMO_W-1:0]      wait_cnt;
    logic [3:0]            bit_idx;
    logic [SRCH_W-1:0]     search;
    logic [BIAS_W-1:0]     bias;
    logic                  adc_busy;
    logic                  cal_sequencer_busy_flag;
    logic                  test_pin;
  } plvc_ctrl_state_t;

  localparam plvc_ctrl_state_t CTRL_RST = '{
    main_div: MAIN_DIV_RST,
    bleed:    BLEED_RST,
    lock_cfg: LOCK_CFG_RST,
    cal_clk:  CAL_CLK_RST,
    cal_tmo:  CAL_TMO_RST,
    band_div: BAND_DIV_RST,
    manual:   MANUAL_RST,
    st:       CAL_IDLE,
    default:  '0};

  plvc_ctrl_state_t q;
  plvc_ctrl_state_t d;
  logic             req;
  logic             wr_done;
  logic             start;
  logic             cal_step;
  logic             ld_enable;
  logic             ld_locked;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] read_word;

  // Byte lanes merged into a register word
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old,
                                                 input logic [DATA_W-1:0] wd,
                                                 input logic [3:0]        be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  // A zero count would wrap and wait 32768 ticks, so it waits one tick
  function automatic logic [TMO_W-1:0] wait_load(input logic [TMO_W-1:0] v);
    wait_load = (v == '0) ? 15'h0001 : v;
  endfunction

  assign req       = avs_read | avs_write;
  assign wr_done   = avs_write & q.ack;
  assign start     = wr_done && (avs_address == OFF_MAIN_DIV);
  assign cal_step  = cal_tick & q.cal_clk[CC_REF_EN_BIT] & q.cal_clk[CC_FB_EN_BIT];
  assign ld_enable = q.lock_cfg[LC_LOL_BIT] & q.lock_cfg[LC_WEN_BIT];

  plvc_lock_det u_lock_det (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .clk_en          (clk_en),
    .enable          (ld_enable),
    .pfd_tick        (pfd_tick),
    .phase_in_window (phase_in_window),
    .count_sel       (q.lock_cfg[LC_CNT_LSB +: LDSEL_W]),
    .locked          (ld_locked)
  );

  always_comb begin
    status_word = '0;
    status_word[ST_LOCK_BIT] = ld_locked;
    status_word[ST_ADC_BIT]  = q.adc_busy;
    status_word[ST_FSM_BIT]  = q.cal_sequencer_busy_flag;
    status_word[ST_CORE_LSB +: CORE_W] = q.search[SRCH_W-1 -: CORE_W];
    status_word[ST_BAND_LSB +: BAND_W] = q.search[BAND_W-1:0];
    status_word[ST_BIAS_LSB +: BIAS_W] = q.bias;
  end

  always_comb begin
    case (avs_address)
      OFF_MAIN_DIV: read_word = q.main_div;
      OFF_BLEED:    read_word = q.bleed;
      OFF_LOCK_CFG: read_word = q.lock_cfg;
      OFF_CAL_CLK:  read_word = q.cal_clk;
      OFF_CAL_TMO:  read_word = q.cal_tmo;
      OFF_BAND_DIV: read_word = q.band_div;
      OFF_MANUAL:   read_word = q.manual;
      OFF_STATUS:   read_word = status_word;
      default:      read_word = '0;
    endcase
  end

  always_comb begin
    d = q;
    // One wait state: answer in the cycle after the request appears
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.rdata = read_word;
    end
    if (wr_done) begin
      case (avs_address)
        OFF_MAIN_DIV: d.main_div = be_merge(q.main_div, avs_writedata, avs_byteenable);
        OFF_BLEED:    d.bleed    = be_merge(q.bleed, avs_writedata, avs_byteenable);
        OFF_LOCK_CFG: d.lock_cfg = be_merge(q.lock_cfg, avs_writedata, avs_byteenable);
        OFF_CAL_CLK:  d.cal_clk  = be_merge(q.cal_clk, avs_writedata, avs_byteenable);
        OFF_CAL_TMO:  d.cal_tmo  = be_merge(q.cal_tmo, avs_writedata, avs_byteenable);
        OFF_BAND_DIV: d.band_div = be_merge(q.band_div, avs_writedata, avs_byteenable);
        OFF_MANUAL:   d.manual   = be_merge(q.manual, avs_writedata, avs_byteenable);
        default:      d.main_div = q.main_div;
      endcase
    end

    // core and band search, then bias
    case (q.st)
      CAL_IDLE: begin
        d.st = CAL_IDLE;
      end
      CAL_SETTLE: begin
        if (cal_step) begin
          if (q.wait_cnt == 15'h0001) begin
            d.st       = CAL_SEARCH;
            d.bit_idx  = 4'h9;
            d.search   = 10'h200;
            d.wait_cnt = wait_load({7'h00, q.band_div[BD_DIV_LSB +: BDIV_W]});
          end else begin
            d.wait_cnt = q.wait_cnt - 15'h0001;
          end
        end
      end
      CAL_SEARCH: begin
        if (cal_step) begin
          if (q.wait_cnt == 15'h0001) begin
            // Trial too fast: drop this bit
            if (!osc_freq_low) begin
              d.search[q.bit_idx] = 1'b0;
            end
            if (q.bit_idx == 4'h0) begin
              d.st       = CAL_AMP;
              d.wait_cnt = wait_load(q.cal_tmo[CT_ALC_LSB +: TMO_W]);
            end else begin
              d.bit_idx             = q.bit_idx - 4'h1;
              d.search[q.bit_idx - 4'h1] = 1'b1;
              d.wait_cnt = wait_load({7'h00, q.band_div[BD_DIV_LSB +: BDIV_W]});
            end
          end else begin
            d.wait_cnt = q.wait_cnt - 15'h0001;
          end
        end
      end
      CAL_AMP: begin
        // Converter clock must run for the amplitude loop
        if (cal_step && q.cal_clk[CC_ADC_EN_BIT]) begin
          if (q.wait_cnt == 15'h0001) begin
            d.bias = amp_level;
            d.st   = CAL_ADC_END;
          end else begin
            d.wait_cnt = q.wait_cnt - 15'h0001;
          end
        end
      end
      CAL_ADC_END: begin
        d.adc_busy = 1'b0;
        d.st       = CAL_FSM_END;
      end
      CAL_FSM_END: begin
        d.cal_sequencer_busy_flag = 1'b0;
        d.st       = CAL_IDLE;
      end
      default: begin
        d.st       = CAL_IDLE;
        d.adc_busy = 1'b0;
        d.cal_sequencer_busy_flag = 1'b0;
      end
    endcase

    // a new write restarts any run in progress
    if (start) begin
      d.adc_busy = 1'b1;
      d.cal_sequencer_busy_flag = 1'b1;
      if (q.manual[MN_EN_BIT]) begin
        d.search = {q.manual[MN_CORE_LSB +: CORE_W], q.manual[MN_BAND_LSB +: BAND_W]};
        d.bias   = q.manual[MN_BIAS_LSB +: BIAS_W];
        d.st     = CAL_ADC_END;
      end else begin
        d.search   = '0;
        d.st       = CAL_SETTLE;
        d.wait_cnt = wait_load(q.cal_tmo[CT_SYN_LSB +: TMO_W]);
      end
    end

    case (q.lock_cfg[LC_MUX_LSB +: MUX_W])
      MUX_SEL_LOCK: d.test_pin = ld_locked;
      MUX_SEL_FSM:  d.test_pin = q.cal_sequencer_busy_flag;
      MUX_SEL_ADC:  d.test_pin = q.adc_busy;
      default:      d.test_pin = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= CTRL_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Held while clock enable is low so no access is lost
  assign avs_waitrequest = req & ~(q.ack & clk_en);
  assign avs_readdata    = q.rdata;

  assign bleed_source_on = q.bleed[BL_EN_BIT] & q.bleed[BL_DIR_BIT];
  assign bleed_sink_on   = q.bleed[BL_EN_BIT] & ~q.bleed[BL_DIR_BIT];
  assign bleed_magnitude = q.bleed[BL_MAG_LSB +: BLEED_W];
  assign lock_window_width          = q.lock_cfg[LC_WIN_BIT];
  assign output_logic_level_select  = q.lock_cfg[LC_LVL_BIT];
  assign lock_indicate_pin          = ld_locked;
  assign test_output_pin            = q.test_pin;
  assign feedback_divide            = q.main_div[MD_NINT_LSB +: 12];
  assign output_divide_select       = q.main_div[MD_ODIV_LSB +: 2];
  assign reference_divide           = q.main_div[MD_RDIV_LSB +: 6];
  assign reference_doubler_enable   = q.main_div[MD_DBL_BIT];
  assign cal_clock_first_divider    = q.cal_clk[CC_DIV1_LSB +: 2];
  assign cal_clock_second_divider   = q.cal_clk[CC_DIV2_LSB +: 2];
  assign cal_clock_mode             = q.cal_clk[CC_MODE_BIT];
  assign cal_count_select           = q.cal_clk[CC_CT_BIT];
  assign cal_ref_clock_enable       = q.cal_clk[CC_REF_EN_BIT];
  assign cal_feedback_clock_enable  = q.cal_clk[CC_FB_EN_BIT];
  assign cal_adc_clock_enable       = q.cal_clk[CC_ADC_EN_BIT];
  assign adc_clock_divide           = q.cal_clk[CC_ADIV_LSB +: ADIV_W];
  assign oscillator_core_result     = q.search[SRCH_W-1 -: CORE_W];
  assign oscillator_band_result     = q.search[BAND_W-1:0];
  assign oscillator_bias_result     = q.bias;

  bleed_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && wr_done && avs_address == OFF_BLEED && avs_byteenable[1] && !avs_writedata[BL_EN_BIT]
    |=> !bleed_source_on && !bleed_sink_on) else $error("bleed left on after disable");

  bleed_dir_a: assert property (@(posedge sys_clk) disable iff (reset)
    bleed_source_on |-> !bleed_sink_on && q.bleed[BL_DIR_BIT]) else $error("bleed direction wrong");

  cal_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && start |=> q.adc_busy && q.cal_sequencer_busy_flag && q.st != CAL_IDLE) else $error("calibration not started");

  busy_order_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(q.cal_sequencer_busy_flag) |-> !q.adc_busy && !$past(q.adc_busy)) else $error("sequencer busy fell first");

  adc_fall_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(q.adc_busy) |-> q.cal_sequencer_busy_flag) else $error("converter busy fell after sequencer");

  mux_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && q.lock_cfg[LC_MUX_LSB +: MUX_W] == MUX_SEL_LOCK && !wr_done
    |=> test_output_pin == $past(ld_locked)) else $error("test pin misses lock");

  manual_load_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && start && q.manual[MN_EN_BIT]
    |=> oscillator_band_result == $past(q.manual[MN_BAND_LSB +: BAND_W])) else $error("manual band not loaded");

  bus_answer_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && req && !q.ack ##1 clk_en && req |-> !avs_waitrequest) else $error("bus answer late");

endmodule // plvc_ctrl

// file: plvc_ctrl_bench.sv
// Self-checking bench for the lock detect, bleed and calibration control
`timescale 1ns/1ps
module plvc_ctrl_bench;
  import plvc_pkg::*;
  logic              sys_clk = 1'b0;
  logic              reset   = 1'b1;
  logic [ADDR_W-1:0] adr     = '0;
  logic              rd      = 1'b0;
  logic              wr      = 1'b0;
  logic [DATA_W-1:0] wdat    = '0;
  logic              pfd_tick = 1'b0;
  logic              in_win  = 1'b0;
  logic              cal_tick = 1'b0;
  logic              freq_low = 1'b0;
  logic [BIAS_W-1:0] amp     = '0;
  logic [DATA_W-1:0] rdat;
  logic              wait_req;
  logic              src_on;
  logic              snk_on;
  logic [BLEED_W-1:0] mag;
  logic              lock_pin;
  logic              test_pin;
  logic [11:0]       fb_div;
  logic [5:0]        ref_div;
  logic              dbl;
  logic              ce      = 1'b1;
  logic              win_w;
  wire  [2:0]        cal_en;
  wire  [12:0]       osc_res;
  int                fails = 0;
  int                cmp_count = 0;

  plvc_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(ce), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wait_req), .pfd_tick(pfd_tick), .phase_in_window(in_win), .cal_tick(cal_tick),
    .osc_freq_low(freq_low), .amp_level(amp), .bleed_source_on(src_on), .bleed_sink_on(snk_on),
    .bleed_magnitude(mag), .lock_window_width(win_w), .lock_indicate_pin(lock_pin), .test_output_pin(test_pin),
    .output_logic_level_select(), .feedback_divide(fb_div), .output_divide_select(), .reference_divide(ref_div),
    .reference_doubler_enable(dbl), .cal_clock_first_divider(), .cal_clock_second_divider(),
    .cal_clock_mode(), .cal_count_select(), .cal_ref_clock_enable(cal_en[0]),
    .cal_feedback_clock_enable(cal_en[1]), .cal_adc_clock_enable(cal_en[2]), .adc_clock_divide(),
    .oscillator_core_result(osc_res[12:11]), .oscillator_band_result(osc_res[10:3]),
    .oscillator_bias_result(osc_res[2:0]));

  always #20 sys_clk = ~sys_clk;

  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low, data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      stop_test();
    end else begin
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Issues n PFD ticks with the window flag at w, then rests two cycles
  task automatic ticks(input int n, input logic w);
    repeat (n) begin
      @(posedge sys_clk);
      pfd_tick <= 1'b1;
      in_win <= w;
    end
    @(posedge sys_clk);
    pfd_tick <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic t_regs;
    rd_chk(OFF_CAL_CLK, CAL_CLK_RST);
    rd_chk(OFF_CAL_TMO, CAL_TMO_RST);
    rd_chk(OFF_BAND_DIV, BAND_DIV_RST);
    rd_chk(8'h20, 32'h0);
    wr_reg(OFF_STATUS, 32'hFFFF_FFFF);
    rd_chk(OFF_STATUS, 32'h0);
  endtask

  task automatic t_bleed;
    logic [31:0] tbl [3] = '{32'h0000_33FF, 32'h0000_1155, 32'h0000_2200};
    foreach (tbl[i]) begin
      wr_reg(OFF_BLEED, tbl[i]);
      chk(src_on, tbl[i][12] & tbl[i][13]);
      chk(snk_on, tbl[i][12] & !tbl[i][13]);
      chk(mag, tbl[i][9:0]);
    end
  endtask

  task automatic t_lock;
    wr_reg(OFF_LOCK_CFG, 32'h0006_0401);
    ticks(40, 1'b1);
    chk(lock_pin, 1'b0);
    wr_reg(OFF_LOCK_CFG, 32'h0006_0701);
    chk(win_w, 1'b1);
    ticks(20, 1'b1);
    ticks(1, 1'b0);
    ticks(31, 1'b1);
    chk(lock_pin, 1'b0);
    ticks(1, 1'b1);
    chk(lock_pin, 1'b1);
    chk(test_pin, 1'b1);
    rd_chk(OFF_STATUS, 32'h1);
    // Clock enable low freezes the lock
    ce <= 1'b0;
    ticks(1, 1'b0);
    chk(lock_pin, 1'b1);
    ce <= 1'b1;
    ticks(1, 1'b0);
    chk(lock_pin, 1'b0);
  endtask

  task automatic t_cal;
    logic [31:0] q;
    int adc_at;
    int fsm_at;
    wr_reg(OFF_MANUAL, 32'h8005_A702);
    wr_reg(OFF_MAIN_DIV, 32'h0011_6123);
    chk({dbl, ref_div, fb_div}, {1'b1, 6'h05, 12'h123});
    rd_chk(OFF_STATUS, 32'h0005_A720);
    chk(osc_res, {2'h2, 8'hA7, 3'h5});
    wr_reg(OFF_MANUAL, 32'h0);
    wr_reg(OFF_LOCK_CFG, 32'h0008_0000);
    freq_low <= 1'b1;
    cal_tick <= 1'b1;
    amp <= 3'h5;
    wr_reg(OFF_MAIN_DIV, 32'h0000_0064);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk(q[2:1], 2'b11);
    chk(test_pin, 1'b1);
    adc_at = 0;
    fsm_at = 0;
    for (int i = 1; i < 200 && fsm_at == 0; i++) begin
      bus(1'b0, OFF_STATUS, 32'h0, q);
      if (q[1] === 1'b0 && adc_at == 0) adc_at = i;
      if (q[2] === 1'b0) fsm_at = i;
    end
    chk(fsm_at > 0 && adc_at <= fsm_at, 1'b1);
    chk(q, 32'h0005_FF30);
    chk(osc_res, {2'h3, 8'hFF, 3'h5});
    chk(test_pin, 1'b0);
    wr_reg(OFF_CAL_CLK, 32'h0000_0001);
    chk(cal_en, 3'b000);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_bleed();
    t_lock();
    t_cal();
    stop_test();
  end
endmodule // plvc_ctrl_bench

// file: plvc_lock_det.sv
// Phase window lock detector counting consecutive in-window PFD cycles
`timescale 1ns/1ps
module plvc_lock_det (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire logic                  enable,
  input  wire logic                  pfd_tick,
  input  wire logic                  phase_in_window,
  input  wire logic [plvc_pkg::LDSEL_W-1:0] count_sel,
  output logic                       locked
);
  import plvc_pkg::*;

  typedef struct packed {
    plvc_ldcnt_t cnt;
    logic        locked;
  } plvc_ld_state_t;

  plvc_ld_state_t q;
  plvc_ld_state_t d;

  function automatic plvc_ldcnt_t ld_target(input logic [LDSEL_W-1:0] sel);
    ld_target = LD_TABLE[sel];
  endfunction

  always_comb begin
    d = q;
    if (!enable) begin
      d.cnt    = '0;
      d.locked = 1'b0;
    end else if (!phase_in_window) begin
      d.cnt    = '0;
      d.locked = 1'b0;
    end else if (pfd_tick && !q.locked) begin
      d.cnt = q.cnt + 21'h000001;
      if (d.cnt >= ld_target(count_sel)) begin
        d.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign locked = q.locked;

  lock_drop_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !phase_in_window |=> !locked) else $error("lock held outside window");

  lock_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !enable |=> !locked && q.cnt == '0) else $error("lock high while disabled");

  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && enable && !phase_in_window |=> q.cnt == '0) else $error("count kept after exit");

  lock_rise_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(locked) |-> q.cnt == ld_target($past(count_sel))) else $error("lock rose off threshold");

endmodule // plvc_lock_det

// file: plvc_pkg.sv
// Constants, register map and types of the loop lock and oscillator calibration control
package plvc_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int LD_CNT_W = 21;
  localparam int CORE_W   = 2;
  localparam int BAND_W   = 8;
  localparam int BIAS_W   = 3;
  localparam int SRCH_W   = CORE_W + BAND_W;
  localparam int TMO_W    = 15;
  localparam int BLEED_W  = 10;
  localparam int MUX_W    = 5;
  localparam int LDSEL_W  = 5;
  localparam int BDIV_W   = 8;
  localparam int ADIV_W   = 8;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_MAIN_DIV = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BLEED    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LOCK_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CAL_CLK  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CAL_TMO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BAND_DIV = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MANUAL   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h1C;

  // Field positions
  localparam int MD_NINT_LSB   = 0;
  localparam int MD_ODIV_LSB   = 12;
  localparam int MD_RDIV_LSB   = 14;
  localparam int MD_DBL_BIT    = 20;
  localparam int BL_MAG_LSB    = 0;
  localparam int BL_EN_BIT     = 12;
  localparam int BL_DIR_BIT    = 13;
  localparam int LC_CNT_LSB    = 0;
  localparam int LC_WIN_BIT    = 8;
  localparam int LC_LOL_BIT    = 9;
  localparam int LC_WEN_BIT    = 10;
  localparam int LC_MUX_LSB    = 16;
  localparam int LC_LVL_BIT    = 24;
  localparam int CC_DIV1_LSB   = 0;
  localparam int CC_DIV2_LSB   = 2;
  localparam int CC_MODE_BIT   = 4;
  localparam int CC_CT_BIT     = 5;
  localparam int CC_REF_EN_BIT = 8;
  localparam int CC_FB_EN_BIT  = 9;
  localparam int CC_ADC_EN_BIT = 10;
  localparam int CC_ADIV_LSB   = 16;
  localparam int CT_SYN_LSB    = 0;
  localparam int CT_ALC_LSB    = 16;
  localparam int BD_DIV_LSB    = 0;
  localparam int MN_CORE_LSB   = 0;
  localparam int MN_BAND_LSB   = 8;
  localparam int MN_BIAS_LSB   = 16;
  localparam int MN_EN_BIT     = 31;
  localparam int ST_LOCK_BIT   = 0;
  localparam int ST_ADC_BIT    = 1;
  localparam int ST_FSM_BIT    = 2;
  localparam int ST_CORE_LSB   = 4;
  localparam int ST_BAND_LSB   = 8;
  localparam int ST_BIAS_LSB   = 16;

  // Values after reset
  localparam logic [DATA_W-1:0] MAIN_DIV_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BLEED_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] LOCK_CFG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CAL_CLK_RST  = 32'h0000_0701;
  localparam logic [DATA_W-1:0] CAL_TMO_RST  = 32'h0001_0001;
  localparam logic [DATA_W-1:0] BAND_DIV_RST = 32'h0000_0001;
  localparam logic [DATA_W-1:0] MANUAL_RST   = 32'h0000_0000;

  // Test output selections
  localparam logic [MUX_W-1:0] MUX_SEL_LOCK = 5'h06;
  localparam logic [MUX_W-1:0] MUX_SEL_FSM  = 5'h07;
  localparam logic [MUX_W-1:0] MUX_SEL_ADC  = 5'h08;

  // Required in-window PFD cycles per count select code
  typedef logic [LD_CNT_W-1:0] plvc_ldcnt_t;
  localparam plvc_ldcnt_t [0:31] LD_TABLE = '{
    21'h00017, 21'h00020, 21'h0002F, 21'h00042, 21'h0005F, 21'h00086, 21'h000BF, 21'h0010E,
    21'h0017F, 21'h0021E, 21'h002FF, 21'h0043D, 21'h005FF, 21'h0087B, 21'h00BFF, 21'h010F7,
    21'h017FF, 21'h021EF, 21'h02FFF, 21'h043E0, 21'h05FFF, 21'h087C2, 21'h0BFFF, 21'h10F86,
    21'h17FFF, 21'h21F0D, 21'h2FFFF, 21'h43E1C, 21'h5FFFF, 21'h87C3A, 21'hBFFFF, 21'h10F875};

  typedef enum logic [2:0] {
    CAL_IDLE    = 3'b000,
    CAL_SETTLE  = 3'b001,
    CAL_SEARCH  = 3'b010,
    CAL_AMP     = 3'b011,
    CAL_ADC_END = 3'b100,
    CAL_FSM_END = 3'b101
  } plvc_cal_state_t;

endpackage
